// >>> rtl/asp_pkg.sv
// Purpose: constants and carrier types for the static memory host port
// Assumes: 250 MHz reference clock
// Notes: times in ns, cycle counts derived from the clock period
package asp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PS = 4000;
  // Timing figures in ns
  localparam int T_CYCLE_NS = 20;
  localparam int T_ACCESS_NS = 20;
  localparam int T_WPULSE_NS = 15;
  localparam int T_DSETUP_NS = 10;
  localparam int T_AHOLD_NS = 1;
  localparam int T_TURN_NS = 9;
  // Least times round up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int CYC_ACCESS = ns_to_cyc(T_ACCESS_NS) + 1;
  localparam int CYC_WPULSE = ns_to_cyc(T_WPULSE_NS);
  localparam int CYC_DSETUP = ns_to_cyc(T_DSETUP_NS);
  localparam int CYC_AHOLD = ns_to_cyc(T_AHOLD_NS);
  localparam int CYC_GAP = ns_to_cyc(T_CYCLE_NS);
  localparam int CYC_TURN = ns_to_cyc(T_TURN_NS);
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACCESS,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_GAP
  } asp_state_type;

  // Pin group toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_select_n;
    logic output_enable_n;
    logic write_enable_n;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } asp_pins_type;

  typedef struct packed {
    asp_state_type state;
    logic [CNT_W-1:0] cnt;
    asp_pins_type pins;
    logic busy;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic wr_done;
  } asp_regs_type;
endpackage

// >>> rtl/asp_host.sv
// Purpose: host controller driving an asynchronous 32K x 8 static memory
// Assumes: pins sampled synchronously to ref_clk_i; one request at a time
// Notes: chip select framed reads and write-enable framed writes
//        requests that arrive while busy are dropped with no indication
//        write data and address stay one cycle past the write end; zero would do for the data
//        reads sample one cycle past the access time, trading latency for margin
//
// Behaviour
// R01: Memory holds 32768 words of eight bits, chosen by fifteen address lines.
// R02: Memory keeps contents with no clock or refresh from us.
// R03: Chip select high deselects memory; bus floats whatever other strobes do.
// R04: While selected, write enable low writes, high reads; output enable gates drive.
// R05: Select low, output enable low, write enable high: memory drives stored word.
// R06: With select and output enable held low, output follows address after access.
// R07: Address is valid no later than chip select falling for reads.
// R08: Write occurs only while chip select and write enable are both low.
// R09: Write starts with all controls valid; first rising strobe ends it.
// R10: Write data stable at least 10 ns before the ending edge.
// R11: Write data may be released at the ending edge.
// R12: Address valid 15 ns before write end, held 1 ns after.
// R13: With output enable high during write, memory keeps outputs floating.
// R14: Cycles spaced at least 20 ns; never drive bus while memory drives. After a read, chip select stays high only 16 ns before the next cycle.
`timescale 1ns/1ps
module asp_host
  import asp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic busy_o,
  output logic rd_valid_o,
  output logic [DATA_W-1:0] rd_data_o,
  output logic wr_done_o,
  output logic [ADDR_W-1:0] word_address_bus_o,
  output logic chip_select_n_o,
  output logic output_enable_n_o,
  output logic write_enable_n_o,
  input wire logic [DATA_W-1:0] shared_data_bus_i,
  output logic [DATA_W-1:0] shared_data_bus_o,
  output logic shared_data_bus_oe_o
);

  // ****************************************
  // State
  // ****************************************
  asp_regs_type r;
  asp_regs_type next_r;

  // ****************************************
  // Helpers
  // ****************************************
  // Every phase loads its whole wait and leaves on a count of one, so a
  // wait of N cycles costs exactly N edges in its state
  function automatic logic last_tick(input logic [CNT_W-1:0] cnt);
    return cnt == CNT_W'(1);
  endfunction

  // Counters never wrap: they are only stepped while last_tick is false
  function automatic logic [CNT_W-1:0] tick_down(input logic [CNT_W-1:0] cnt);
    return cnt - CNT_W'(1);
  endfunction

  // ****************************************
  // Sequencing
  // ****************************************
  // All pins come from the state register so timing is cycle exact
  always_comb
  begin
    next_r = r;
    next_r.rd_valid = 1'b0;
    next_r.wr_done = 1'b0;
    case (r.state)
      ST_IDLE:
      begin
        next_r.busy = 1'b0;
        if (req_valid_i)
        begin
          next_r.busy = 1'b1;
          // R07 address first
          next_r.pins.addr = req_addr_i;
          next_r.pins.chip_select_n = 1'b0;
          if (req_write_i)
          begin
            // R09 controls valid
            next_r.pins.output_enable_n = 1'b1;
            next_r.pins.write_enable_n = 1'b1;
            next_r.pins.data_out = req_wdata_i;
            next_r.cnt = CNT_W'(CYC_TURN);
            next_r.state = ST_WR_SETUP;
          end
          else
          begin
            // R05 read drive
            next_r.pins.write_enable_n = 1'b1;
            next_r.pins.output_enable_n = 1'b0;
            next_r.pins.data_oe = 1'b0;
            next_r.cnt = CNT_W'(CYC_ACCESS);
            next_r.state = ST_RD_ACCESS;
          end
        end
      end
      ST_RD_ACCESS:
      begin
        // R06 access wait
        // One cycle beyond the access time covers the memory's output settling
        if (last_tick(r.cnt))
        begin
          next_r.rd_data = shared_data_bus_i;
          next_r.rd_valid = 1'b1;
          // R03 deselect
          next_r.pins.chip_select_n = 1'b1;
          next_r.pins.output_enable_n = 1'b1;
          next_r.cnt = CNT_W'(CYC_TURN);
          next_r.state = ST_GAP;
        end
        else
          next_r.cnt = tick_down(r.cnt);
      end
      ST_WR_SETUP:
      begin
        // R14 bus turnaround, R13 memory floats with output enable high
        // Output enable went high at acceptance; wait out the float time first
        if (last_tick(r.cnt))
        begin
          next_r.pins.data_oe = 1'b1;
          // R08 write window opens
          next_r.pins.write_enable_n = 1'b0;
          next_r.cnt = CNT_W'((CYC_WPULSE > CYC_DSETUP) ? CYC_WPULSE : CYC_DSETUP);
          next_r.state = ST_WR_PULSE;
        end
        else
          next_r.cnt = tick_down(r.cnt);
      end
      ST_WR_PULSE:
      begin
        // R10 data setup, R12 address setup
        if (last_tick(r.cnt))
        begin
          next_r.pins.write_enable_n = 1'b1;
          next_r.cnt = CNT_W'(CYC_AHOLD);
          next_r.state = ST_WR_HOLD;
        end
        else
          next_r.cnt = tick_down(r.cnt);
      end
      ST_WR_HOLD:
      begin
        // R12 address hold, R11 data released after end
        // Write enable alone ends the write, so chip select may rise later
        if (last_tick(r.cnt))
        begin
          next_r.pins.data_oe = 1'b0;
          next_r.pins.chip_select_n = 1'b1;
          next_r.wr_done = 1'b1;
          next_r.cnt = CNT_W'(CYC_GAP);
          next_r.state = ST_GAP;
        end
        else
          next_r.cnt = tick_down(r.cnt);
      end
      ST_GAP:
      begin
        // R14 spacing between cycles
        if (last_tick(r.cnt))
        begin
          next_r.busy = 1'b0;
          next_r.state = ST_IDLE;
        end
        else
          next_r.cnt = tick_down(r.cnt);
      end
      default:
      begin
        // Unused codes fall back to idle; pins keep their last level till then
        next_r.state = ST_IDLE;
      end
    endcase
  end

  // State register; strobes inactive and bus released at reset
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r.state <= ST_IDLE;
      r.cnt <= '0;
      r.pins.addr <= '0;
      r.pins.chip_select_n <= 1'b1;
      r.pins.output_enable_n <= 1'b1;
      r.pins.write_enable_n <= 1'b1;
      r.pins.data_out <= '0;
      r.pins.data_oe <= 1'b0;
      r.busy <= 1'b0;
      r.rd_valid <= 1'b0;
      r.rd_data <= '0;
      r.wr_done <= 1'b0;
    end
    else
      r <= next_r;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Straight off the state register, so every pin leaves a flip-flop
  assign busy_o = r.busy;
  assign rd_valid_o = r.rd_valid;
  assign rd_data_o = r.rd_data;
  assign wr_done_o = r.wr_done;
  assign word_address_bus_o = r.pins.addr;
  assign chip_select_n_o = r.pins.chip_select_n;
  assign output_enable_n_o = r.pins.output_enable_n;
  assign write_enable_n_o = r.pins.write_enable_n;
  assign shared_data_bus_o = r.pins.data_out;
  assign shared_data_bus_oe_o = r.pins.data_oe;

endmodule // asp_host

// >>> testbench/asp_sram_model.sv
// Purpose: behavioural static memory
// Assumes: strobes active low
// Notes: bus shows the inverted addressed word when not read
`timescale 1ns/1ps
module asp_sram_model
  import asp_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [DATA_W-1:0] din_i,
  output logic [DATA_W-1:0] dout_o
);
  logic [DATA_W-1:0] mem [0:32767];
  logic [DATA_W-1:0] rd;
  wire wr_on = !cs_n_i && !we_n_i;
  always @(negedge wr_on)
  begin
    mem[addr_i] = din_i;
  end
  assign #20 rd = mem[addr_i];
  assign dout_o = (!cs_n_i && !oe_n_i && we_n_i) ? rd : ~rd;
endmodule // asp_sram_model

// >>> testbench/asp_host_asserts.sv
// Purpose: pin timing checks
// Assumes: one clock
// Notes: bound to asp_host
`timescale 1ns/1ps
module asp_host_asserts
  import asp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic busy_o,
  input wire logic rd_valid_o,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic wr_done_o,
  input wire logic [ADDR_W-1:0] word_address_bus_o,
  input wire logic chip_select_n_o,
  input wire logic output_enable_n_o,
  input wire logic write_enable_n_o,
  input wire logic [DATA_W-1:0] shared_data_bus_i,
  input wire logic [DATA_W-1:0] shared_data_bus_o,
  input wire logic shared_data_bus_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic tk_q;
  wire take = req_valid_i && !busy_o && !tk_q;
  // Marks the accepting edge
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i) tk_q <= 1'b0;
    else tk_q <= take;
  end
  a_rd_latency: assert property (take && !req_write_i |-> ##7 rd_valid_o)
    else $error("read answer late");
  a_rd_capture: assert property (rd_valid_o |-> rd_data_o == $past(shared_data_bus_i))
    else $error("read data not bus");
  a_wr_latency: assert property (take && req_write_i |-> ##9 wr_done_o)
    else $error("write answer late");
  a_addr_first: assert property (take |=> !chip_select_n_o && word_address_bus_o == $past(req_addr_i))
    else $error("address not with select");
  a_we_in_cs: assert property (!write_enable_n_o |-> !chip_select_n_o)
    else $error("write strobe outside select");
  a_no_fight: assert property (shared_data_bus_oe_o |-> output_enable_n_o &&
    $past(output_enable_n_o) && $past(output_enable_n_o, 2) && $past(output_enable_n_o, 3))
    else $error("bus driven by both");
  a_data_setup: assert property ($rose(write_enable_n_o) |->
    $past(shared_data_bus_oe_o, 3) && shared_data_bus_o == $past(shared_data_bus_o, 3))
    else $error("write data setup short");
  a_addr_hold: assert property ($rose(write_enable_n_o) |->
    word_address_bus_o == $past(word_address_bus_o, 4) ##1 $stable(word_address_bus_o))
    else $error("write address window short");
  a_cs_gap: assert property ($rose(chip_select_n_o) |-> chip_select_n_o[*4])
    else $error("cycles too close");
endmodule // asp_host_asserts
bind asp_host asp_host_asserts u_chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .req_valid_i(req_valid_i),
  .req_write_i(req_write_i),
  .req_addr_i(req_addr_i),
  .req_wdata_i(req_wdata_i),
  .busy_o(busy_o),
  .rd_valid_o(rd_valid_o),
  .rd_data_o(rd_data_o),
  .wr_done_o(wr_done_o),
  .word_address_bus_o(word_address_bus_o),
  .chip_select_n_o(chip_select_n_o),
  .output_enable_n_o(output_enable_n_o),
  .write_enable_n_o(write_enable_n_o),
  .shared_data_bus_i(shared_data_bus_i),
  .shared_data_bus_o(shared_data_bus_o),
  .shared_data_bus_oe_o(shared_data_bus_oe_o)
);

// >>> testbench/asp_host_test.sv
// Purpose: self-checking bench
// Assumes: model on the memory pins
// Notes: fixed waits cover a whole cycle
`timescale 1ns/1ps
module asp_host_test
  import asp_pkg::*;
;
  typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} asp_row_type;
  logic ref_clk_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, cs_n, oe_n, we_n, doe, busy, rdv, wrd;
  logic [ADDR_W-1:0] req_addr_i = '0, addr;
  logic [DATA_W-1:0] req_wdata_i = '0, rdata, dout, mdout, bus;
  int bad_count = 0, compares = 0, cyc = 0;
  asp_row_type rows [6] = '{'{1, 15'h0000, 8'h5a}, '{1, 15'h7fff, 8'ha5}, '{1, 15'h0001, 8'h3c},
    '{0, 15'h0000, 8'h5a}, '{0, 15'h7fff, 8'ha5}, '{0, 15'h0001, 8'h3c}};
  always #2 ref_clk_i = ~ref_clk_i;
  assign bus = doe ? dout : mdout;
  asp_host dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .busy_o(busy), .rd_valid_o(rdv), .rd_data_o(rdata),
    .wr_done_o(wrd), .word_address_bus_o(addr), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
    .write_enable_n_o(we_n), .shared_data_bus_i(bus), .shared_data_bus_o(dout), .shared_data_bus_oe_o(doe));
  asp_sram_model mem (.addr_i(addr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n), .din_i(bus), .dout_o(mdout));
  task chk(input string n, input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  // One request, then wait out the cycle and its gap
  task op(input asp_row_type r);
    logic [DATA_W-1:0] n_rd;
    logic [DATA_W-1:0] n_wr;
    n_rd = 8'h00;
    n_wr = 8'h00;
    @(negedge ref_clk_i);
    {req_write_i, req_addr_i, req_wdata_i} = r;
    req_valid_i = 1;
    @(negedge ref_clk_i);
    req_valid_i = 0;
    chk("busy", {7'h00, busy}, 8'h01);
    // Each answer pulse lasts one cycle, so it is seen at exactly one falling edge
    repeat (20)
    begin
      @(negedge ref_clk_i);
      n_rd = n_rd + {7'h00, rdv};
      n_wr = n_wr + {7'h00, wrd};
    end
    chk("busy", {7'h00, busy}, 8'h00);
    chk("rd_valid", n_rd, {7'h00, !r.w});
    chk("wr_done", n_wr, {7'h00, r.w});
    if (!r.w) chk("rd_data", rdata, r.d);
  endtask
  task close_out;
    if (bad_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      close_out;
    end
  end
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 0;
    foreach (rows[i]) op(rows[i]);
    // A request held while busy is taken once: address 1 gets c3, not the later 99
    @(negedge ref_clk_i);
    {req_write_i, req_addr_i, req_wdata_i} = {1'h1, 15'h0001, 8'hc3};
    req_valid_i = 1;
    @(negedge ref_clk_i);
    req_wdata_i = 8'h99;
    repeat (2) @(negedge ref_clk_i);
    req_valid_i = 0;
    repeat (20) @(negedge ref_clk_i);
    // Reset in the middle of a read drops every strobe at once
    {req_write_i, req_addr_i} = {1'h0, 15'h0001};
    req_valid_i = 1;
    @(negedge ref_clk_i);
    req_valid_i = 0;
    repeat (2) @(negedge ref_clk_i);
    chk("read_strobes", {6'h00, cs_n, oe_n}, 8'h00);
    rst_i = 1;
    @(negedge ref_clk_i);
    chk("strobes", {cs_n, oe_n, we_n, busy, 3'h0, doe}, 8'he0);
    rst_i = 0;
    op('{0, 15'h0001, 8'hc3});
    close_out;
  end
endmodule // asp_host_test
